// >>> verilog/dtcu_defs.vh
// Constants for the dual timer/counter unit
`ifndef DTCU_DEFS_VH
`define DTCU_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses (special function register space)
// ----------------------------------------------------------------------
`define DTCU_SFR_BASE 8'h80
`define DTCU_ADDR_TIMER_CONTROL 8'h88
`define DTCU_ADDR_MODE_CONFIG 8'h89
`define DTCU_ADDR_CHAN0_LOW 8'h8a
`define DTCU_ADDR_CHAN1_LOW 8'h8b
`define DTCU_ADDR_CHAN0_HIGH 8'h8c
`define DTCU_ADDR_CHAN1_HIGH 8'h8d

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DTCU_MODE_LO0 0
`define DTCU_MODE_HI0 1
`define DTCU_CT_SEL0 2
`define DTCU_GATE0 3
`define DTCU_MODE_LO1 4
`define DTCU_MODE_HI1 5
`define DTCU_CT_SEL1 6
`define DTCU_GATE1 7
`define DTCU_RUN0_BIT 4
`define DTCU_OVF0_BIT 5
`define DTCU_RUN1_BIT 6
`define DTCU_OVF1_BIT 7

// ----------------------------------------------------------------------
// Modes and reset values
// ----------------------------------------------------------------------
`define DTCU_MODE_13BIT 2'h0
`define DTCU_MODE_16BIT 2'h1
`define DTCU_MODE_RELOAD 2'h2
`define DTCU_MODE_SPLIT 2'h3
`define DTCU_RST_MODE 8'h00
`define DTCU_RST_COUNT 8'h00
`define DTCU_RST_CONTROL 8'h00

// ----------------------------------------------------------------------
// Timing: machine cycle is six peripheral clocks
// ----------------------------------------------------------------------
`define DTCU_PERIPH_PER_TICK 3'h6
`define DTCU_TICK_CNT_W 3

`endif

// >>> verilog/dtcu_timer_unit.v
// Dual 16-bit timer/counter unit with its special function registers
`timescale 1ns/1ps
`include "dtcu_defs.vh"

module dtcu_timer_unit (
  input wire clk_sys,
  input wire rst_b,
  input wire fast_cycle_mode,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output reg sfr_hit,
  input wire chan0_count_pin,
  input wire chan1_count_pin,
  input wire chan0_gate_pin,
  input wire chan1_gate_pin,
  input wire chan0_irq_en,
  input wire chan1_irq_en,
  output reg chan0_irq,
  output reg chan1_irq,
  output reg chan0_overflow,
  output reg chan1_overflow
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [7:0] timer_mode_config;
  reg [7:0] timer_control_low;
  reg chan0_run, chan1_run;
  reg [7:0] chan0_count_low, chan0_count_high;
  reg [7:0] chan1_count_low, chan1_count_high;
  reg [7:0] next_c0l, next_c0h, next_c1l, next_c1h;
  reg set_ovf0, set_ovf1;

  // ----------------------------------------------------------------------
  // Clock divider: peripheral clock and machine cycle
  // ----------------------------------------------------------------------
  reg periph_half;
  reg [`DTCU_TICK_CNT_W-1:0] tick_cnt;
  wire periph_en, tick;

  // Slow mode drops every other system clock
  assign periph_en = fast_cycle_mode | periph_half;
  assign tick = periph_en &
    (tick_cnt == (`DTCU_PERIPH_PER_TICK - 3'h1));

  // Divider; a tick is a one-cycle enable, never a derived clock
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      periph_half <= 1'b0;
      tick_cnt <= {`DTCU_TICK_CNT_W{1'b0}};
    end
    else
    begin
      periph_half <= ~periph_half;
      if (tick)
        tick_cnt <= {`DTCU_TICK_CNT_W{1'b0}};
      else if (periph_en)
        tick_cnt <= tick_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and per-cycle edge sampling
  // ----------------------------------------------------------------------
  reg [3:0] pin_meta, pin_sync;
  reg [1:0] cnt_prev, cnt_samp;
  wire [3:0] pins_raw;
  wire [1:0] fall;

  assign pins_raw = {chan1_gate_pin, chan0_gate_pin,
    chan1_count_pin, chan0_count_pin};

  // Two flops on every pin; only the second stage feeds logic
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      pin_meta <= pins_raw;
      pin_sync <= pin_meta;
    end
  end

  // Sample once per machine cycle; a glitch shorter than that is seen only if it spans a tick
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_samp <= 2'h0;
      cnt_prev <= 2'h0;
    end
    else if (tick)
    begin
      cnt_samp <= pin_sync[1:0];
      cnt_prev <= cnt_samp;
    end
  end

  // Falling edge seen across two consecutive samples
  assign fall = cnt_prev & ~cnt_samp;

  // ----------------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------------
  wire [1:0] mode0, mode1;
  wire split, inc0, inc1, inc0h;

  assign mode0 = timer_mode_config[`DTCU_MODE_HI0:`DTCU_MODE_LO0];
  assign mode1 = timer_mode_config[`DTCU_MODE_HI1:`DTCU_MODE_LO1];
  assign split = (mode0 == `DTCU_MODE_SPLIT);

  // Counter or timer source per channel gating
  assign inc0 = chan0_run &
    (~timer_mode_config[`DTCU_GATE0] | pin_sync[2]) &
    // Edge level stands a whole machine cycle; count it on one tick only
    (timer_mode_config[`DTCU_CT_SEL0] ? (fall[0] & tick) : tick);
  // In split mode the run bit belongs to the high byte of channel 0
  assign inc1 = (split | chan1_run) &
    (~timer_mode_config[`DTCU_GATE1] | pin_sync[3]) &
    (timer_mode_config[`DTCU_CT_SEL1] ? (fall[1] & tick) : tick) &
    (mode1 != `DTCU_MODE_SPLIT);
  // Split high byte is always an internal timer
  assign inc0h = split & chan1_run & tick;

  // ----------------------------------------------------------------------
  // Next-count logic per channel
  // ----------------------------------------------------------------------
  // Channel 0
  always @*
  begin
    next_c0l = chan0_count_low;
    next_c0h = chan0_count_high;
    set_ovf0 = 1'b0;
    if (inc0)
    begin
      case (mode0)
        `DTCU_MODE_13BIT:
        begin
          // Upper three low bits take no part and stay put
          next_c0l = {chan0_count_low[7:5], chan0_count_low[4:0] + 5'h01};
          if (chan0_count_low[4:0] == 5'h1f)
          begin
            next_c0h = chan0_count_high + 8'h01;
            set_ovf0 = (chan0_count_high == 8'hff);
          end
        end
        `DTCU_MODE_16BIT:
        begin
          next_c0l = chan0_count_low + 8'h01;
          if (chan0_count_low == 8'hff)
          begin
            next_c0h = chan0_count_high + 8'h01;
            set_ovf0 = (chan0_count_high == 8'hff);
          end
        end
        `DTCU_MODE_RELOAD:
        begin
          if (chan0_count_low == 8'hff)
          begin
            next_c0l = chan0_count_high;
            set_ovf0 = 1'b1;
          end
          else
            next_c0l = chan0_count_low + 8'h01;
        end
        default:
        begin
          // Split low byte: plain 8-bit counter
          next_c0l = chan0_count_low + 8'h01;
          set_ovf0 = (chan0_count_low == 8'hff);
        end
      endcase
    end
  end

  // Channel 1; overflow goes nowhere while channel 0 is split
  always @*
  begin
    next_c1l = chan1_count_low;
    next_c1h = chan1_count_high;
    set_ovf1 = 1'b0;
    if (inc0h)
      set_ovf1 = (chan0_count_high == 8'hff);
    if (inc1)
    begin
      case (mode1)
        `DTCU_MODE_13BIT:
        begin
          next_c1l = {chan1_count_low[7:5], chan1_count_low[4:0] + 5'h01};
          if (chan1_count_low[4:0] == 5'h1f)
          begin
            next_c1h = chan1_count_high + 8'h01;
            if (!split)
              set_ovf1 = (chan1_count_high == 8'hff);
          end
        end
        `DTCU_MODE_16BIT:
        begin
          next_c1l = chan1_count_low + 8'h01;
          if (chan1_count_low == 8'hff)
          begin
            next_c1h = chan1_count_high + 8'h01;
            if (!split)
              set_ovf1 = (chan1_count_high == 8'hff);
          end
        end
        `DTCU_MODE_RELOAD:
        begin
          if (chan1_count_low == 8'hff)
          begin
            next_c1l = chan1_count_high;
            if (!split)
              set_ovf1 = 1'b1;
          end
          else
            next_c1l = chan1_count_low + 8'h01;
        end
        default: next_c1l = chan1_count_low; // Frozen
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register file: direct access, bit ops arrive as read-modify-write
  // ----------------------------------------------------------------------
  wire in_sfr, wr_ctl, wr_mode;

  // Only the upper half of the byte space is special registers
  assign in_sfr = sfr_addr[7];
  assign wr_ctl = sfr_wr & in_sfr & (sfr_addr == `DTCU_ADDR_TIMER_CONTROL);
  assign wr_mode = sfr_wr & in_sfr & (sfr_addr == `DTCU_ADDR_MODE_CONFIG);

  // Counters: hardware update, software write overrides
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chan0_count_low <= `DTCU_RST_COUNT;
      chan0_count_high <= `DTCU_RST_COUNT;
      chan1_count_low <= `DTCU_RST_COUNT;
      chan1_count_high <= `DTCU_RST_COUNT;
    end
    else
    begin
      chan0_count_low <= (sfr_wr && sfr_addr == `DTCU_ADDR_CHAN0_LOW) ?
        sfr_wdata : next_c0l;
      chan1_count_low <= (sfr_wr && sfr_addr == `DTCU_ADDR_CHAN1_LOW) ?
        sfr_wdata : next_c1l;
      chan1_count_high <= (sfr_wr && sfr_addr == `DTCU_ADDR_CHAN1_HIGH) ?
        sfr_wdata : next_c1h;
      if (sfr_wr && sfr_addr == `DTCU_ADDR_CHAN0_HIGH)
        chan0_count_high <= sfr_wdata;
      else if (inc0h)
        chan0_count_high <= chan0_count_high + 8'h01;
      else
        chan0_count_high <= next_c0h;
    end
  end

  // Mode, control and flags; a hardware set beats a software clear
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_mode_config <= `DTCU_RST_MODE;
      timer_control_low <= `DTCU_RST_CONTROL;
      chan0_run <= 1'b0;
      chan1_run <= 1'b0;
      chan0_overflow <= 1'b0;
      chan1_overflow <= 1'b0;
      chan0_irq <= 1'b0;
      chan1_irq <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_config <= sfr_wdata;
      if (wr_ctl)
      begin
        timer_control_low <= {4'h0, sfr_wdata[3:0]};
        chan0_run <= sfr_wdata[`DTCU_RUN0_BIT];
        chan1_run <= sfr_wdata[`DTCU_RUN1_BIT];
      end
      if (set_ovf0)
        chan0_overflow <= 1'b1;
      else if (wr_ctl)
        chan0_overflow <= sfr_wdata[`DTCU_OVF0_BIT];
      if (set_ovf1)
        chan1_overflow <= 1'b1;
      else if (wr_ctl)
        chan1_overflow <= sfr_wdata[`DTCU_OVF1_BIT];
      // Interrupt requests follow flag and enable, same-cycle set included
      chan0_irq <= chan0_irq_en & (chan0_overflow | set_ovf0);
      chan1_irq <= chan1_irq_en & (chan1_overflow | set_ovf1);
    end
  end

  // ----------------------------------------------------------------------
  // Read path, registered one cycle after the strobe
  // ----------------------------------------------------------------------
  reg [7:0] next_rdata;
  reg next_hit;

  // Unknown addresses answer zero with no hit
  always @*
  begin
    next_hit = sfr_rd & in_sfr;
    next_rdata = 8'h00;
    case (sfr_addr)
      `DTCU_ADDR_TIMER_CONTROL:
        next_rdata = {chan1_overflow, chan1_run, chan0_overflow, chan0_run,
          timer_control_low[3:0]};
      `DTCU_ADDR_MODE_CONFIG: next_rdata = timer_mode_config;
      `DTCU_ADDR_CHAN0_LOW: next_rdata = chan0_count_low;
      `DTCU_ADDR_CHAN1_LOW: next_rdata = chan1_count_low;
      `DTCU_ADDR_CHAN0_HIGH: next_rdata = chan0_count_high;
      `DTCU_ADDR_CHAN1_HIGH: next_rdata = chan1_count_high;
      default: next_hit = 1'b0; // Reserved space
    endcase
    if (!next_hit)
      next_rdata = 8'h00;
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end
    else
    begin
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end
  end

endmodule // dtcu_timer_unit

// >>> test/dtcu_pin_model.sv
// Far-side model of the count and gate pins of both channels
`timescale 1ns/1ps
module dtcu_pin_model (
  input wire clk_sys,
  output reg chan0_count_pin,
  output reg chan1_count_pin,
  output reg chan0_gate_pin,
  output reg chan1_gate_pin
);
  // Idle levels; count pins rest high so no edge is seen
  initial
  begin
    chan0_count_pin = 1'b1;
    chan1_count_pin = 1'b1;
    chan0_gate_pin = 1'b0;
    chan1_gate_pin = 1'b1;
  end

  // Each level spans over two machine cycles, else a sample is missed
  task pulses(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1)
      begin
        repeat (14) @(posedge clk_sys);
        chan0_count_pin <= 1'b0;
        repeat (14) @(posedge clk_sys);
        chan0_count_pin <= 1'b1;
      end
      repeat (14) @(posedge clk_sys);
    end
  endtask

  // Gate level for pulse-width measurement
  task gate(input v);
    begin
      @(posedge clk_sys);
      chan0_gate_pin <= v;
    end
  endtask
endmodule // dtcu_pin_model

// >>> test/dtcu_timer_unit_checker.sv
// Port checker for the dual timer/counter unit
`timescale 1ns/1ps
module dtcu_timer_unit_checker (
  input wire clk_sys,
  input wire rst_b,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire sfr_hit,
  input wire chan0_irq_en,
  input wire chan1_irq_en,
  input wire chan0_irq,
  input wire chan1_irq,
  input wire chan0_overflow,
  input wire chan1_overflow
);
  // ------------------------------------------------
  // Bus and flag properties
  // ------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Mode write, one idle bus cycle, then a mode read
  sequence wr_mode;
    sfr_wr && sfr_addr == 8'h89;
  endsequence
  sequence rd_mode;
    sfr_rd && !sfr_wr && sfr_addr == 8'h89;
  endsequence

  rd_low_a: assert property (
    sfr_rd && sfr_addr < 8'h80 |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read below register space answered");
  rd_map_a: assert property (
    sfr_rd && sfr_addr >= 8'h88 && sfr_addr <= 8'h8d |=> sfr_hit)
    else $error("mapped read not acknowledged");
  rd_idle_a: assert property (
    !sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("read data without a read");
  mode_echo_a: assert property (
    wr_mode ##1 !sfr_wr ##1 rd_mode |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("mode register did not keep written value");
  ovf_mirror_a: assert property (
    sfr_rd && sfr_addr == 8'h88 |=> sfr_rdata[5] == $past(chan0_overflow)
      && sfr_rdata[7] == $past(chan1_overflow))
    else $error("control read disagrees with flags");
  flag0_hold_a: assert property (
    chan0_overflow && !(sfr_wr && sfr_addr == 8'h88) |=> chan0_overflow)
    else $error("channel 0 flag dropped by itself");
  flag1_hold_a: assert property (
    chan1_overflow && !(sfr_wr && sfr_addr == 8'h88) |=> chan1_overflow)
    else $error("channel 1 flag dropped by itself");
  flag_set_a: assert property (
    sfr_wr && sfr_addr == 8'h88 && sfr_wdata[5] |=> chan0_overflow)
    else $error("software set of flag lost");
  irq0_rise_a: assert property (
    $rose(chan0_overflow) && chan0_irq_en |=> chan0_irq)
    else $error("channel 0 interrupt missing");
  irq1_rise_a: assert property (
    $rose(chan1_overflow) && chan1_irq_en |=> chan1_irq)
    else $error("channel 1 interrupt missing");
  irq_cause_a: assert property (
    chan0_irq |-> $past(chan0_irq_en)
      && (chan0_overflow || $past(chan0_overflow)))
    else $error("channel 0 interrupt without cause");
endmodule // dtcu_timer_unit_checker

bind dtcu_timer_unit dtcu_timer_unit_checker u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .chan0_irq_en(chan0_irq_en),
  .chan1_irq_en(chan1_irq_en), .chan0_irq(chan0_irq),
  .chan1_irq(chan1_irq), .chan0_overflow(chan0_overflow),
  .chan1_overflow(chan1_overflow));

// >>> test/dtcu_timer_unit_bench.sv
// Self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
module dtcu_timer_unit_bench;
  reg clk_sys, rst_b, fast_cycle_mode, sfr_wr, sfr_rd;
  reg [7:0] sfr_addr, sfr_wdata, d, d1;
  reg chan0_irq_en, chan1_irq_en, h;
  wire [7:0] sfr_rdata;
  wire sfr_hit, chan0_irq, chan1_irq, chan0_overflow, chan1_overflow;
  wire cnt0, cnt1, gate0, gate1;
  integer error_cnt, n_compared, i, k;

  // 20 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  dtcu_timer_unit u_dtcu_timer_unit (
    .clk_sys(clk_sys), .rst_b(rst_b), .fast_cycle_mode(fast_cycle_mode),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .chan0_count_pin(cnt0), .chan1_count_pin(cnt1),
    .chan0_gate_pin(gate0), .chan1_gate_pin(gate1),
    .chan0_irq_en(chan0_irq_en), .chan1_irq_en(chan1_irq_en),
    .chan0_irq(chan0_irq), .chan1_irq(chan1_irq),
    .chan0_overflow(chan0_overflow), .chan1_overflow(chan1_overflow));
  dtcu_pin_model u_dtcu_pin_model (
    .clk_sys(clk_sys), .chan0_count_pin(cnt0), .chan1_count_pin(cnt1),
    .chan0_gate_pin(gate0), .chan1_gate_pin(gate1));

  // ------------------------------------------------
  // Access and check tasks
  // ------------------------------------------------
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= v;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
    end
  endtask
  // Read data stands for one cycle; taken at the edge that sees the hit
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk_sys);
      sfr_rd <= 1'b0;
      @(posedge clk_sys);
      d = sfr_rdata;
      h = sfr_hit;
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wait_ovf(input ch);
    begin
      i = 0;
      while ((ch ? chan1_overflow : chan0_overflow) !== 1'b1 && i < 400)
      begin
        @(posedge clk_sys);
        i = i + 1;
      end
      // A flag that lands on the last pass is not a timeout
      if ((ch ? chan1_overflow : chan0_overflow) !== 1'b1)
      begin
        chk("timeout", 8'h00, 8'h01);
        report_and_stop;
      end
    end
  endtask
  task chk_rng(input [7:0] v);
    chk("rate", (v >= 9 && v <= 11) ? 8'h01 : 8'h00, 8'h01);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    rst_b = 1'b0;
    fast_cycle_mode = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    chan0_irq_en = 1'b0;
    chan1_irq_en = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 8'h88; k <= 8'h8d; k = k + 1)
    begin
      rd(k[7:0]);
      chk("reset", d, 8'h00);
      chk("hit", {7'h0, h}, 8'h01);
    end
    rd(8'h8e);
    // Reserved addresses are only ever read, never written
    chk("unmap", d | {7'h0, h}, 8'h00);
    rd(8'h40);
    chk("low", d | {7'h0, h}, 8'h00);
    wr(8'h88, 8'ha0);
    rd(8'h88);
    chk("ctl", d, 8'ha0);
    wr(8'h89, 8'ha5);
    rd(8'h89);
    chk("mode", d, 8'ha5);
    // Tick rate in slow then fast cycle mode, same tick count expected
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h01);
    for (k = 0; k <= 1; k = k + 1)
    begin
      fast_cycle_mode <= k[0];
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      repeat (60 * (2 - k)) @(posedge clk_sys);
      wr(8'h88, 8'h00);
      rd(8'h8a);
      chk_rng(d);
    end
    // Mode 0 wrap, then carry out of the five low bits
    chan0_irq_en <= 1'b1;
    wr(8'h89, 8'h00);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    wait_ovf(1'b0);
    rd(8'h8c);
    chk("m0wrap", d, 8'h00);
    chk("irq0", {7'h0, chan0_irq}, 8'h01);
    rd(8'h88);
    chk("ctlovf", d, 8'h30);
    wr(8'h88, 8'h10);
    wr(8'h8c, 8'h7f);
    wr(8'h8a, 8'h3f);
    repeat (30) @(posedge clk_sys);
    rd(8'h8c);
    chk("m0carry", d, 8'h80);
    chk("irq0off", {7'h0, chan0_irq}, 8'h00);
    // Mode 1 wrap through all 16 bits
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h01);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hfd);
    wr(8'h88, 8'h10);
    wait_ovf(1'b0);
    rd(8'h8a);
    chk("m1low", d, 8'h00);
    rd(8'h8c);
    chk("m1high", d, 8'h00);
    // Mode 2 reload on channel 1, then freeze in mode 3
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h20);
    wr(8'h8d, 8'ha5);
    wr(8'h8b, 8'hfe);
    chan1_irq_en <= 1'b1;
    wr(8'h88, 8'h40);
    wait_ovf(1'b1);
    rd(8'h8b);
    chk("reload", d, 8'ha5);
    rd(8'h8d);
    chk("rldhigh", d, 8'ha5);
    chk("irq1", {7'h0, chan1_irq}, 8'h01);
    wr(8'h89, 8'h30);
    wr(8'h8b, 8'h55);
    repeat (40) @(posedge clk_sys);
    rd(8'h8b);
    chk("frozen", d, 8'h55);
    // Split mode: high byte on channel 1 run, low byte on its own
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h40);
    wait_ovf(1'b1);
    chk("lowidle", {7'h0, chan0_overflow}, 8'h00);
    wr(8'h88, 8'h10);
    wait_ovf(1'b0);
    chk("lowovf", {7'h0, chan1_overflow}, 8'h00);
    // Channel 1 runs out of its mode 3 with no run bit
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h13);
    wr(8'h8b, 8'h00);
    repeat (60) @(posedge clk_sys);
    wr(8'h89, 8'h33);
    rd(8'h8b);
    chk_rng(d);
    d1 = d;
    repeat (30) @(posedge clk_sys);
    rd(8'h8b);
    chk("stop1", d, d1);
    // Gated edge counting on the channel 0 count pin
    wr(8'h89, 8'h0d);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'h00);
    wr(8'h88, 8'h10);
    u_dtcu_pin_model.pulses(3);
    rd(8'h8a);
    chk("gated", d, 8'h00);
    u_dtcu_pin_model.gate(1'b1);
    u_dtcu_pin_model.pulses(4);
    rd(8'h8a);
    chk("edges", d, 8'h04);
    report_and_stop;
  end
endmodule // dtcu_timer_unit_bench
